// >>> counter_array.sv
/*
 * Programmable counter array: shared 16-bit counter, five
 * compare/capture modules, guard timer on module 4, register port.
 * Assumes pins and register strobes are synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module counter_array
    import counter_array_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [7:0]        wr_data_in,
    input  wire logic              wr_en_in,
    input  wire logic              rd_en_in,
    output logic [7:0]             rd_data_out,
    // System
    input  wire logic              idle_mode_in,
    input  wire logic              timer0_ovf_in,
    output logic                   irq_out,
    output logic                   guard_reset_out,
    // Port pins
    input  wire logic              count_pin_in,
    input  wire logic [4:0]        module_pin_in,
    output logic [4:0]             module_pin_out,
    output logic [4:0]             module_pin_oe_n_out
);
    logic [7:0]  counter_mode_reg;
    logic        overflow_flag_reg;
    logic        counter_run_reg;
    logic [4:0]  event_flag_reg;
    logic [15:0] count_reg;
    logic        step_reg;
    logic        wrap_low_reg;
    logic [7:0]  rd_data_reg;
    logic [7:0]  rd_data_next;
    logic        irq_reg;
    logic        guard_reset_reg;
    logic [7:0]  module_mode_reg [NUM_MODULES];
    logic [7:0]  cmp_low  [NUM_MODULES];
    logic [7:0]  cmp_high [NUM_MODULES];
    logic [4:0]  match;
    logic [4:0]  event_hit;
    logic [4:0]  pin_level;
    logic [4:0]  pin_drive;
    logic        tick;
    logic        advance;
    logic        overflow;
    logic        wr_mode;
    logic        wr_control;
    logic        wr_count_low;
    logic        wr_count_high;
    logic [7:0]  control_view;
    logic [4:0]  irq_enables;
    count_source_type source;

    // ==========================================================
    // Write decode
    assign wr_mode       = wr_en_in && (addr_in == MODE_ADDR);
    assign wr_control    = wr_en_in && (addr_in == CONTROL_ADDR);
    assign wr_count_low  = wr_en_in && (addr_in == COUNT_LOW_ADDR);
    assign wr_count_high = wr_en_in && (addr_in == COUNT_HI_ADDR);

    assign source = count_source_type'(
        counter_mode_reg[SRC_HI_BIT:SRC_LO_BIT]);

    // ==========================================================
    // Count source
    counter_array_tick u_tick (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .source_in     (source),
        .timer0_ovf_in (timer0_ovf_in),
        .count_pin_in  (count_pin_in),
        .tick_out      (tick)
    );

    // Run gate and idle stop
    assign advance = tick && counter_run_reg
        && !(counter_mode_reg[IDLE_HALT_BIT] && idle_mode_in);
    assign overflow = advance && (count_reg == COUNT_MAX);

    // ==========================================================
    // Mode register; reserved bits stay zero
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            counter_mode_reg <= REG_RESET;
        end else if (wr_mode) begin
            counter_mode_reg <= wr_data_in & MODE_WR_MASK;
        end
    end

    // Shared counter; a software write wins over a tick
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_reg <= COUNT_RESET;
        end else if (wr_count_low) begin
            count_reg[7:0] <= wr_data_in;
        end else if (wr_count_high) begin
            count_reg[15:8] <= wr_data_in;
        end else if (advance) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // Step markers: modules compare on the value just reached
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            step_reg     <= 1'b0;
            wrap_low_reg <= 1'b0;
        end else begin
            step_reg     <= advance && !wr_count_low && !wr_count_high;
            wrap_low_reg <= advance && !wr_count_low && !wr_count_high
                            && (count_reg[7:0] == LOW_MAX);
        end
    end

    // Run bit, plain software control
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            counter_run_reg <= 1'b0;
        end else if (wr_control) begin
            counter_run_reg <= wr_data_in[RUN_BIT];
        end
    end

    // Overflow flag: only software clears, and a set in the same
    // cycle wins so no overflow is lost
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            overflow_flag_reg <= 1'b0;
        end else begin
            overflow_flag_reg <= overflow
                | (wr_control ? wr_data_in[OVF_FLAG_BIT]
                              : overflow_flag_reg);
        end
    end

    // Module event flags, set beats clear
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            event_flag_reg <= 5'h00;
        end else begin
            event_flag_reg <= event_hit
                | (wr_control ? wr_data_in[4:0] : event_flag_reg);
        end
    end

    // ==========================================================
    // Compare/capture modules
    genvar g;
    generate
        for (g = 0; g < NUM_MODULES; g++) begin : g_mod
            logic wr_mod_mode;
            assign wr_mod_mode = wr_en_in
                && (addr_in == MOD_MODE_BASE + 5'(g));

            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    module_mode_reg[g] <= REG_RESET;
                end else if (wr_mod_mode) begin
                    module_mode_reg[g] <= wr_data_in & MOD_MODE_MASK;
                end
            end

            // Module 4 is an ordinary module; the guard only taps
            // its match line
            counter_array_module u_mod (
                .clk_in       (clk_in),
                .resetn_in    (resetn_in),
                .count_in     (count_reg),
                .step_in      (step_reg),
                .wrap_low_in  (wrap_low_reg),
                .mode_in      (module_mode_reg[g]),
                .wr_low_in    (wr_en_in
                               && (addr_in == CMP_LOW_BASE + 5'(g))),
                .wr_high_in   (wr_en_in
                               && (addr_in == CMP_HIGH_BASE + 5'(g))),
                .wr_data_in   (wr_data_in),
                .pin_in       (module_pin_in[g]),
                .pin_out      (pin_level[g]),
                .drive_out    (pin_drive[g]),
                .cmp_low_out  (cmp_low[g]),
                .cmp_high_out (cmp_high[g]),
                .match_out    (match[g]),
                .event_out    (event_hit[g])
            );

            assign irq_enables[g] = module_mode_reg[g][MOD_IRQ_BIT];
        end
    endgenerate

    // Pins not claimed by a module are left released
    assign module_pin_out      = pin_level;
    assign module_pin_oe_n_out = ~pin_drive;

    // ==========================================================
    // Shared interrupt line
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (overflow_flag_reg
                        && counter_mode_reg[OVF_IRQ_EN_BIT])
                     || |(event_flag_reg & irq_enables);
        end
    end
    assign irq_out = irq_reg;

    // Guard timer: a pulse for the system reset controller only;
    // nothing here reaches the external reset pin
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            guard_reset_reg <= 1'b0;
        end else begin
            guard_reset_reg <= counter_mode_reg[GUARD_EN_BIT]
                               && match[GUARD_MOD];
        end
    end
    assign guard_reset_out = guard_reset_reg;

    // ==========================================================
    // Read path, data valid in the cycle after the strobe
    assign control_view = {overflow_flag_reg, counter_run_reg,
                           1'b0, event_flag_reg};

    always_comb begin
        rd_data_next = REG_RESET;
        if (addr_in == MODE_ADDR) begin
            rd_data_next = counter_mode_reg;
        end else if (addr_in == CONTROL_ADDR) begin
            rd_data_next = control_view;
        end else if (addr_in == COUNT_LOW_ADDR) begin
            rd_data_next = count_reg[7:0];
        end else if (addr_in == COUNT_HI_ADDR) begin
            rd_data_next = count_reg[15:8];
        end
        for (int i = 0; i < NUM_MODULES; i++) begin
            if (addr_in == MOD_MODE_BASE + 5'(i)) begin
                rd_data_next = module_mode_reg[i];
            end
            if (addr_in == CMP_LOW_BASE + 5'(i)) begin
                rd_data_next = cmp_low[i];
            end
            if (addr_in == CMP_HIGH_BASE + 5'(i)) begin
                rd_data_next = cmp_high[i];
            end
        end
    end

    // Data returns to zero outside the answer cycle
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_data_reg <= REG_RESET;
        end else begin
            rd_data_reg <= rd_en_in ? rd_data_next : REG_RESET;
        end
    end
    assign rd_data_out = rd_data_reg;

    // ==========================================================
    // Checks
    a_count_step: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        advance && !wr_count_low && !wr_count_high
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter did not advance by one");

    a_count_hold: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        !counter_run_reg && !wr_count_low && !wr_count_high
        |=> $stable(count_reg))
        else $error("stopped counter moved");

    a_idle_stop: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        counter_mode_reg[IDLE_HALT_BIT] && idle_mode_in
        && !wr_count_low && !wr_count_high |=> $stable(count_reg))
        else $error("counter moved during idle halt");

    a_overflow_set: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        overflow |=> overflow_flag_reg && count_reg == COUNT_RESET)
        else $error("overflow not flagged");

    a_overflow_sticky: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        overflow_flag_reg && !wr_control |=> overflow_flag_reg)
        else $error("overflow flag cleared without write");

    a_event_flag: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        event_hit[0] |=> event_flag_reg[0])
        else $error("module event not flagged");

    a_irq_source: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        irq_out |-> $past(|(event_flag_reg & irq_enables))
        || $past(overflow_flag_reg && counter_mode_reg[OVF_IRQ_EN_BIT]))
        else $error("interrupt without enabled cause");

    a_guard_fire: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        counter_mode_reg[GUARD_EN_BIT] && match[GUARD_MOD]
        |=> guard_reset_out)
        else $error("guard match gave no reset");

    a_guard_quiet: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        guard_reset_out |-> $past(counter_mode_reg[GUARD_EN_BIT]))
        else $error("reset with guard disabled");

    a_read_control: assert property (@(posedge clk_in)
        disable iff (!resetn_in)
        rd_en_in && addr_in == CONTROL_ADDR
        |=> rd_data_out == $past(control_view))
        else $error("control read mismatch");

    c_overflow: cover property (@(posedge clk_in)
        disable iff (!resetn_in) overflow);
    c_capture: cover property (@(posedge clk_in)
        disable iff (!resetn_in) |event_hit ##1 irq_out);
    c_guard: cover property (@(posedge clk_in)
        disable iff (!resetn_in) guard_reset_out);
    c_pwm: cover property (@(posedge clk_in)
        disable iff (!resetn_in) wrap_low_reg && |pin_drive);
endmodule
`default_nettype wire

// >>> counter_array_module.sv
/*
 * One compare/capture module: capture, software timer, toggling
 * output and 8-bit modulation. Holds its own compare registers.
 * Assumes step_in marks the cycle after each counter advance.
 */
`timescale 1ns/1ps
`default_nettype none
module counter_array_module
    import counter_array_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // Shared time base
    input  wire logic [15:0] count_in,
    input  wire logic        step_in,
    input  wire logic        wrap_low_in,
    // Configuration and software writes
    input  wire logic [7:0]  mode_in,
    input  wire logic        wr_low_in,
    input  wire logic        wr_high_in,
    input  wire logic [7:0]  wr_data_in,
    // Pin
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             drive_out,
    // Status
    output logic [7:0]       cmp_low_out,
    output logic [7:0]       cmp_high_out,
    output logic             match_out,
    output logic             event_out
);
    logic [7:0] cmp_low_reg;
    logic [7:0] cmp_high_reg;
    logic       pin_prev_reg;
    logic       pin_reg;
    logic       drive_reg;
    logic       capture;
    logic       pwm_mode;
    logic       flip_mode;

    assign pwm_mode  = mode_in[PWM_EN_BIT] & mode_in[CMP_EN_BIT];
    assign flip_mode = mode_in[FLIP_EN_BIT] & mode_in[HIT_EN_BIT]
                       & mode_in[CMP_EN_BIT];
    // Compare only in the cycle after a step, so a stalled counter
    // resting on the compare value gives one match, not many
    assign match_out = step_in & mode_in[CMP_EN_BIT]
                       & (count_in == {cmp_high_reg, cmp_low_reg});
    assign capture   = (mode_in[CAP_RISE_BIT] & pin_in & ~pin_prev_reg)
                     | (mode_in[CAP_FALL_BIT] & ~pin_in & pin_prev_reg);
    assign event_out = capture
                     | (match_out & mode_in[HIT_EN_BIT]);

    // ==========================================================
    // Compare registers; a capture beats a software write
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cmp_low_reg  <= REG_RESET;
            cmp_high_reg <= REG_RESET;
        end else if (capture) begin
            cmp_low_reg  <= count_in[7:0];
            cmp_high_reg <= count_in[15:8];
        end else begin
            if (wr_high_in) begin
                cmp_high_reg <= wr_data_in;
            end
            if (wr_low_in) begin
                cmp_low_reg <= wr_data_in;
            end else if (pwm_mode && wrap_low_in) begin
                cmp_low_reg <= cmp_high_reg;
            end
        end
    end

    // Pin history for edge detection
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_prev_reg <= PIN_IDLE;
        end else begin
            pin_prev_reg <= pin_in;
        end
    end

    // Output level and drive claim
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_reg   <= PIN_IDLE;
            drive_reg <= 1'b0;
        end else begin
            drive_reg <= pwm_mode | flip_mode;
            if (pwm_mode) begin
                pin_reg <= (count_in[7:0] >= cmp_low_reg);
            end else if (flip_mode && match_out) begin
                pin_reg <= ~pin_reg;
            end
        end
    end

    assign pin_out      = pin_reg;
    assign drive_out    = drive_reg;
    assign cmp_low_out  = cmp_low_reg;
    assign cmp_high_out = cmp_high_reg;
endmodule
`default_nettype wire

// >>> counter_array_pkg.sv
/*
 * Constants shared by the counter array: register map, field positions,
 * reset values, count-source encodings and prescaler figures.
 * Assumes an 8-bit register port with a 5-bit word address.
 */
`default_nettype none
package counter_array_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_MODULES = 5;
    localparam int ADDR_W      = 5;
    localparam int GUARD_MOD   = 4;

    // ==========================================================
    // Register addresses (module registers are base + index)
    localparam logic [4:0] MODE_ADDR      = 5'h00;
    localparam logic [4:0] CONTROL_ADDR   = 5'h01;
    localparam logic [4:0] COUNT_LOW_ADDR = 5'h02;
    localparam logic [4:0] COUNT_HI_ADDR  = 5'h03;
    localparam logic [4:0] MOD_MODE_BASE  = 5'h04;
    localparam logic [4:0] CMP_LOW_BASE   = 5'h09;
    localparam logic [4:0] CMP_HIGH_BASE  = 5'h0e;

    // ==========================================================
    // counter_mode_reg fields
    localparam int IDLE_HALT_BIT  = 7;
    localparam int GUARD_EN_BIT   = 6;
    localparam int SRC_HI_BIT     = 2;
    localparam int SRC_LO_BIT     = 1;
    localparam int OVF_IRQ_EN_BIT = 0;
    localparam logic [7:0] MODE_WR_MASK = 8'hc7;

    // counter_control_reg fields
    localparam int OVF_FLAG_BIT = 7;
    localparam int RUN_BIT      = 6;

    // module_mode_reg fields
    localparam int CMP_EN_BIT   = 6;
    localparam int CAP_RISE_BIT = 5;
    localparam int CAP_FALL_BIT = 4;
    localparam int HIT_EN_BIT   = 3;
    localparam int FLIP_EN_BIT  = 2;
    localparam int PWM_EN_BIT   = 1;
    localparam int MOD_IRQ_BIT  = 0;
    localparam logic [7:0] MOD_MODE_MASK = 8'h7f;

    // ==========================================================
    // Reset values and counter limits
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX   = 16'hffff;
    localparam logic [7:0]  LOW_MAX     = 8'hff;
    localparam logic        PIN_IDLE    = 1'b1;

    // Prescaler: counts 0..5, one div-6 tick per lap
    localparam logic [2:0] PRESC_LAST  = 3'h5;
    localparam logic [2:0] PRESC_RESET = 3'h0;

    typedef enum logic [1:0] {
        SRC_DIV6   = 2'b00,
        SRC_DIV2   = 2'b01,
        SRC_TIMER0 = 2'b10,
        SRC_PIN    = 2'b11
    } count_source_type;
endpackage
`default_nettype wire

// >>> counter_array_tick.sv
/*
 * Count-source selector for the shared counter: prescaled clock,
 * timer 0 overflow pulse or falling edge of the count input pin.
 * Assumes all inputs are synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module counter_array_tick
    import counter_array_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // Source choice and raw sources
    input  wire count_source_type source_in,
    input  wire logic             timer0_ovf_in,
    input  wire logic             count_pin_in,
    // One-cycle tick
    output logic                  tick_out
);
    logic [2:0] presc_reg;
    logic       pin_prev_reg;

    // ==========================================================
    // Prescaler, free running so the tick phase never drifts
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            presc_reg <= PRESC_RESET;
        end else if (presc_reg == PRESC_LAST) begin
            presc_reg <= PRESC_RESET;
        end else begin
            presc_reg <= presc_reg + 3'h1;
        end
    end

    // Previous pin level for falling-edge detection
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_prev_reg <= PIN_IDLE;
        end else begin
            pin_prev_reg <= count_pin_in;
        end
    end

    // Source decode; odd prescaler steps give the divide-by-two
    always_comb begin
        case (source_in)
            SRC_DIV6:   tick_out = (presc_reg == PRESC_LAST);
            SRC_DIV2:   tick_out = presc_reg[0];
            SRC_TIMER0: tick_out = timer0_ovf_in;
            SRC_PIN:    tick_out = pin_prev_reg & ~count_pin_in;
            default:    tick_out = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// >>> pin_model.sv
/* External pin model: count input and the five module pins.
   Assumes the bench asks for count edges and sets outside levels. */
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    // Bench side
    input  wire logic       clk_in,
    input  wire logic       count_req_in,
    input  wire logic [4:0] ext_in,
    // Array side
    input  wire logic [4:0] drv_in,
    input  wire logic [4:0] oe_n_in,
    output var logic        count_pin_out,
    output logic [4:0]      pin_out
);
    // ==========================================
    // One low cycle per request gives one falling edge
    initial count_pin_out = 1'b1;
    always @(posedge clk_in) begin
        count_pin_out <= !count_req_in;
    end
    // Array wins the wire only where its enable is low
    assign pin_out = (drv_in & ~oe_n_in) | (ext_in & oe_n_in);
endmodule
`default_nettype wire

// >>> testbench.sv
/* Bench for the counter array: bus task, pin model, checks.
   Assumes read data stand one cycle after the read strobe. */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import counter_array_pkg::*;
;
    // ==========================================
    // Signals
    logic       clk_in = 1'b0, resetn_in = 1'b0, wr_en = 1'b0;
    logic       rd_en = 1'b0, idle = 1'b0, t0 = 1'b0, creq = 1'b0;
    logic       gseen = 1'b0, p;
    logic [4:0] addr = 5'h00, ext = 5'h1f;
    logic [7:0] wdata = 8'h00;
    int         bad_count = 0, total_checks = 0;
    wire  [7:0] rdata;
    wire        irq, grst, cpin;
    wire  [4:0] pin, drv, oe_n;
    always #25 clk_in = ~clk_in;
    // Latch guard pulses, they last one cycle only
    always @(posedge clk_in)
        if (grst === 1'b1) gseen <= 1'b1;
    counter_array dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
        .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .rd_data_out(rdata), .idle_mode_in(idle),
        .timer0_ovf_in(t0), .irq_out(irq), .guard_reset_out(grst),
        .count_pin_in(cpin), .module_pin_in(pin),
        .module_pin_out(drv), .module_pin_oe_n_out(oe_n));
    pin_model pin_u (.clk_in(clk_in), .count_req_in(creq), .ext_in(ext),
        .drv_in(drv), .oe_n_in(oe_n), .count_pin_out(cpin), .pin_out(pin));
    // ==========================================
    // Tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            bad_count++;
        end
    endtask
    // One strobe cycle; a read compares the word of the next cycle
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= !w;
        @(posedge clk_in);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(negedge clk_in);
        if (!w) chk(rdata, d);
    endtask
    // One count source pulse, then time for the pipeline to settle
    task automatic tick(input logic src_pin);
        @(posedge clk_in);
        if (src_pin) creq <= 1'b1;
        else t0 <= 1'b1;
        @(posedge clk_in);
        creq <= 1'b0;
        t0 <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        bus(1'b1, 5'h13, 8'hff);
        bus(1'b0, 5'h13, 8'h00);
        bus(1'b0, CONTROL_ADDR, 8'h00);
        $display("test 1 done");
        // Timer 0 then pin source; stopped counter ignores ticks
        bus(1'b1, MODE_ADDR, 8'h04);
        bus(1'b1, CONTROL_ADDR, 8'h40);
        repeat (3) tick(1'b0);
        bus(1'b1, MODE_ADDR, 8'h06);
        repeat (2) tick(1'b1);
        bus(1'b1, CONTROL_ADDR, 8'h00);
        tick(1'b1);
        bus(1'b0, COUNT_LOW_ADDR, 8'h05);
        // Prescaled sources over 36 running clocks, any prescaler phase
        bus(1'b1, COUNT_LOW_ADDR, 8'h00);
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, MODE_ADDR, 8'(m * 2));
            bus(1'b1, CONTROL_ADDR, 8'h40);
            repeat (34) @(posedge clk_in);
            bus(1'b1, CONTROL_ADDR, 8'h00);
            bus(1'b0, COUNT_LOW_ADDR, m ? 8'h18 : 8'h06);
        end
        $display("test 2 done");
        // Overflow, shared interrupt, idle halt
        bus(1'b1, MODE_ADDR, 8'h85);
        bus(1'b1, COUNT_LOW_ADDR, 8'hff);
        bus(1'b1, COUNT_HI_ADDR, 8'hff);
        bus(1'b1, CONTROL_ADDR, 8'h40);
        tick(1'b0);
        bus(1'b0, CONTROL_ADDR, 8'hc0);
        chk(8'(irq), 8'h01);
        @(posedge clk_in);
        idle <= 1'b1;
        tick(1'b0);
        idle <= 1'b0;
        bus(1'b0, COUNT_LOW_ADDR, 8'h00);
        bus(1'b1, CONTROL_ADDR, 8'h00);
        @(negedge clk_in);
        chk(8'(irq), 8'h00);
        $display("test 3 done");
        // Module 0 toggles its pin and flags a match
        bus(1'b1, CMP_LOW_BASE, 8'h05);
        bus(1'b1, MOD_MODE_BASE, 8'h4d);
        bus(1'b1, COUNT_LOW_ADDR, 8'h04);
        bus(1'b1, CONTROL_ADDR, 8'h40);
        p = drv[0];
        tick(1'b0);
        chk(8'({oe_n[0], drv[0]}), 8'({1'b0, ~p}));
        bus(1'b0, CONTROL_ADDR, 8'h41);
        chk(8'(irq), 8'h01);
        bus(1'b1, CONTROL_ADDR, 8'h00);
        $display("test 4 done");
        // Module 1 captures on rising edges only
        bus(1'b1, MOD_MODE_BASE + 5'h01, 8'h20);
        bus(1'b1, COUNT_LOW_ADDR, 8'h34);
        bus(1'b1, COUNT_HI_ADDR, 8'h12);
        @(posedge clk_in);
        ext <= 5'h1d;
        bus(1'b0, CMP_LOW_BASE + 5'h01, 8'h00);
        @(posedge clk_in);
        ext <= 5'h1f;
        repeat (2) @(posedge clk_in);
        bus(1'b0, CMP_LOW_BASE + 5'h01, 8'h34);
        bus(1'b0, CMP_HIGH_BASE + 5'h01, 8'h12);
        bus(1'b0, CONTROL_ADDR, 8'h02);
        $display("test 5 done");
        // Guard on module 4, held off once by moving the compare
        bus(1'b1, CMP_LOW_BASE + 5'h04, 8'h36);
        bus(1'b1, CMP_HIGH_BASE + 5'h04, 8'h12);
        bus(1'b1, MODE_ADDR, 8'h44);
        bus(1'b1, MOD_MODE_BASE + 5'h04, 8'h40);
        bus(1'b1, CONTROL_ADDR, 8'h40);
        tick(1'b0);
        bus(1'b1, CMP_LOW_BASE + 5'h04, 8'h40);
        tick(1'b0);
        chk(8'(gseen), 8'h00);
        bus(1'b1, CMP_LOW_BASE + 5'h04, 8'h37);
        tick(1'b0);
        chk(8'(gseen), 8'h01);
        $display("test 6 done");
        // Module 2 modulates; low byte wrap reloads its duty
        bus(1'b1, MOD_MODE_BASE + 5'h02, 8'h42);
        bus(1'b1, CMP_LOW_BASE + 5'h02, 8'h20);
        bus(1'b1, CMP_HIGH_BASE + 5'h02, 8'h05);
        bus(1'b1, COUNT_LOW_ADDR, 8'h20);
        @(negedge clk_in);
        chk(8'({oe_n[2], drv[2]}), 8'h01);
        bus(1'b1, COUNT_LOW_ADDR, 8'hff);
        tick(1'b0);
        bus(1'b0, CMP_LOW_BASE + 5'h02, 8'h05);
        chk(8'({oe_n[2], drv[2]}), 8'h00);
        $display("test 7 done");
        stop_test();
    end
    // Watchdog far beyond the few hundred cycles the tests take
    initial begin
        repeat (3000) @(posedge clk_in);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
